/* cps_pkg.sv */
// constants, types and helper functions shared by the clock pin-strap control block
// Summary of operation
// R01 - out2 pin: low enable, mid disable, high bypass
// R02 - controller never requests bypass with cmos format
// R03 - out5 low: active, common format applies
// R04 - out5 mid: force cmos, others keep common format
// R05 - out5 high: power down, hold pins tristated
// R06 - undriven three-level pin reads as middle
// R07 - offset pin: off, stratum 3/3e, sonet minimum
// R08 - active indicators high only for active input
// R09 - divider pins set out3/out4 ratio to out2
// R10 - multiplier pins choose setting, table dependent
// R11 - bandwidth pins choose pll loop bandwidth
// R12 - cmos pairs single-ended identical, else differential
// R13 - method pin: manual, non-revertive, revertive automatic
// R14 - manual select pins choose input, deglitched
// R15 - three-level pins resolved and filtered before use
package cps_pkg;

	// resolved three-level codes
	localparam logic [1:0] TRI_LOW = 2'h0;
	localparam logic [1:0] TRI_MID = 2'h1;
	localparam logic [1:0] TRI_HIGH = 2'h2;

	// raw pin sense bits: bit 1 above upper threshold, bit 0 below lower one
	localparam int RAW_ABOVE_BIT = 1;
	localparam int RAW_BELOW_BIT = 0;

	// slot of each three-level pin in the internal code vector
	localparam int TRI_PINS = 15;
	localparam int PIN_OUT2 = 0;
	localparam int PIN_OUT5 = 1;
	localparam int PIN_OFFSET = 2;
	localparam int PIN_METHOD = 3;
	localparam int PIN_TABLE = 4;
	localparam int PIN_FMT0 = 5;
	localparam int PIN_FMT1 = 6;
	localparam int PIN_BW0 = 7;
	localparam int PIN_BW1 = 8;
	localparam int PIN_DIV0 = 9;
	localparam int PIN_DIV1 = 10;
	localparam int PIN_MUL0 = 11;

	// manual select reset value: input 1
	localparam logic [1:0] CS_RST = 2'h0;

	// deglitch window: a level must hold this long before it is believed
	localparam int CLK_MHZ = 25;
	localparam int DEGLITCH_NS = 10000;
	localparam int DEGLITCH_CYCLES = (DEGLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 9;
	localparam logic [CNT_W-1:0] DEGLITCH_LAST = CNT_W'(DEGLITCH_CYCLES - 1);

	// output signal formats
	typedef enum logic [2:0] {
		FMT_RESERVED = 3'h0,
		FMT_LVPECL = 3'h1,
		FMT_LVDS = 3'h2,
		FMT_LVDS_LOW = 3'h3,
		FMT_CML = 3'h4,
		FMT_CMOS = 3'h5,
		FMT_DISABLE = 3'h6
	} cps_fmt_t;

	// active input state, gray coded along 1-2-3-4
	typedef enum logic [1:0] {
		SEL_IN1 = 2'h0,
		SEL_IN2 = 2'h1,
		SEL_IN3 = 2'h3,
		SEL_IN4 = 2'h2
	} cps_sel_t;

	// resolve the comparator pair; nothing asserted means floating, so middle
	function automatic logic [1:0] cps_tri_decode(input logic [1:0] raw);
		if (raw[RAW_ABOVE_BIT] && !raw[RAW_BELOW_BIT])
			return TRI_HIGH;
		else if (raw[RAW_BELOW_BIT] && !raw[RAW_ABOVE_BIT])
			return TRI_LOW;
		else
			return TRI_MID; // see R06
	endfunction

	// input number 0..3 to its state code
	function automatic cps_sel_t cps_idx_to_sel(input logic [1:0] idx);
		case (idx)
			2'h0: return SEL_IN1;
			2'h1: return SEL_IN2;
			2'h2: return SEL_IN3;
			default: return SEL_IN4;
		endcase
	endfunction

endpackage

/* cps_deglitch.sv */
// level filter: passes a value on only after it has held steady for the deglitch window
`timescale 1ns/1ns
module cps_deglitch
	import cps_pkg::*;
#(
	parameter int W = 2,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] raw,
	output logic [W-1:0] stable
);

	logic [W-1:0] sample_reg; // last value seen on the pin
	logic [W-1:0] sample_next;
	logic [CNT_W-1:0] count_reg; // cycles the sample has held
	logic [CNT_W-1:0] count_next;
	logic [W-1:0] stable_reg; // believed value
	logic [W-1:0] stable_next;

	// restart the window on every change; a glitch shorter than it never shows
	always_comb
	begin
		sample_next = sample_reg;
		count_next = count_reg;
		stable_next = stable_reg;
		if (raw != sample_reg)
		begin
			sample_next = raw;
			count_next = '0;
		end
		else if (count_reg == DEGLITCH_LAST)
			stable_next = sample_reg; // see R15
		else
			count_next = count_reg + CNT_W'(1);
	end

	// registers only
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sample_reg <= RST_VAL;
			count_reg <= '0;
			stable_reg <= RST_VAL;
		end
		else
		begin
			sample_reg <= sample_next;
			count_reg <= count_next;
			stable_reg <= stable_next;
		end
	end

	assign stable = stable_reg;

endmodule // cps_deglitch

/* cps_strap_ctrl.sv */
// pin-strap decode, output path control and input clock selection of the multiplier
`timescale 1ns/1ns
module cps_strap_ctrl
	import cps_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	// raw three-level pins, two comparator bits each
	input wire logic [1:0] out2_disable_bypass_sel,
	input wire logic [1:0] out5_disable_format_sel,
	input wire logic [1:0] freq_offset_qualify_sel,
	input wire logic [1:0] input_selection_method,
	input wire logic [1:0] frequency_table_sel,
	input wire logic [3:0] output_format_sel,
	input wire logic [3:0] loop_bandwidth_sel,
	input wire logic [3:0] out3_out4_divider_sel,
	input wire logic [7:0] multiplier_sel,
	// manual select pins, shared with the input 3/4 indicators
	input wire logic [1:0] clock_select_in,
	output logic [1:0] clock_select_out,
	output logic clock_select_oe,
	// input health from the monitors
	input wire logic [3:0] input_valid,
	input wire logic frequency_offset_check,
	// path control
	output logic out2_path_enable,
	output logic pll_bypass,
	output logic bypass_refused,
	output logic out5_path_enable,
	output logic out5_tristate,
	output logic [2:0] common_format,
	output logic [2:0] out5_format,
	output logic common_pair_differential,
	output logic out5_pair_differential,
	// frequency offset qualification
	output logic offset_enable,
	output logic offset_sonet_threshold,
	// settings passed to the pll
	output logic [1:0] selection_method,
	output logic [1:0] table_setting,
	output logic [3:0] bandwidth_setting,
	output logic [3:0] divider_setting,
	output logic [7:0] multiplier_setting,
	// active input indicators
	output logic input1_active_ind,
	output logic input2_active_ind
);

	logic [2*TRI_PINS-1:0] tri_raw; // all pins side by side
	logic [2*TRI_PINS-1:0] tri_code; // filtered codes
	logic [1:0] cs_code; // filtered manual select
	logic [1:0] out2_code;
	logic [1:0] out5_code;
	logic [1:0] offset_code;
	logic [1:0] method_code;
	logic [1:0] fmt_code1;
	logic [1:0] fmt_code0;
	logic [3:0] sel_valid; // validity after offset gating
	cps_fmt_t fmt_common;

	assign tri_raw = {multiplier_sel, out3_out4_divider_sel, loop_bandwidth_sel,
		output_format_sel, frequency_table_sel, input_selection_method,
		freq_offset_qualify_sel, out5_disable_format_sel, out2_disable_bypass_sel};

	// resolve then filter each three-level pin; reset to middle like the pull pair
	genvar gi;
	generate
		for (gi = 0; gi < TRI_PINS; gi++)
		begin : g_tri
			cps_deglitch #(.W(2), .RST_VAL(TRI_MID)) u_filt (
				.clk(clk),
				.rst(rst),
				.raw(cps_tri_decode(tri_raw[2*gi +: 2])), // see R06
				.stable(tri_code[2*gi +: 2]) // see R15
			);
		end
	endgenerate

	// manual select pins are only believed once steady
	cps_deglitch #(.W(2), .RST_VAL(CS_RST)) u_cs_filt (
		.clk(clk),
		.rst(rst),
		.raw(clock_select_in),
		.stable(cs_code) // see R14
	);

	assign out2_code = tri_code[2*PIN_OUT2 +: 2];
	assign out5_code = tri_code[2*PIN_OUT5 +: 2];
	assign offset_code = tri_code[2*PIN_OFFSET +: 2];
	assign method_code = tri_code[2*PIN_METHOD +: 2];
	assign fmt_code0 = tri_code[2*PIN_FMT0 +: 2];
	assign fmt_code1 = tri_code[2*PIN_FMT1 +: 2];

	// common format from the pin pair, pin 1 the first letter
	always_comb
	begin
		case ({fmt_code1, fmt_code0})
			{TRI_HIGH, TRI_MID}: fmt_common = FMT_LVDS;
			{TRI_HIGH, TRI_LOW}: fmt_common = FMT_CML;
			{TRI_MID, TRI_HIGH}: fmt_common = FMT_LVPECL;
			{TRI_MID, TRI_LOW}: fmt_common = FMT_LVDS_LOW;
			{TRI_LOW, TRI_HIGH}: fmt_common = FMT_CMOS;
			{TRI_LOW, TRI_MID}: fmt_common = FMT_DISABLE;
			default: fmt_common = FMT_RESERVED; // reserved pairs drive nothing
		endcase
	end

	// path control state
	logic out2_en_reg, out2_en_next;
	logic bypass_reg, bypass_next;
	logic refused_reg, refused_next;
	logic out5_en_reg, out5_en_next;
	logic out5_tri_reg, out5_tri_next;
	logic [2:0] fmt_reg, fmt_next;
	logic [2:0] fmt5_reg, fmt5_next;
	logic diff_reg, diff_next;
	logic diff5_reg, diff5_next;
	logic offset_en_reg, offset_en_next;
	logic offset_sonet_reg, offset_sonet_next;

	// decode path pins; bypass with cmos cannot work, so it is held off and flagged
	always_comb
	begin
		out2_en_next = 1'b1;
		bypass_next = 1'b0;
		refused_next = 1'b0;
		case (out2_code)
			TRI_LOW: out2_en_next = 1'b1; // see R01
			TRI_HIGH:
			begin
				out2_en_next = 1'b1; // see R01
				bypass_next = (fmt_common != FMT_CMOS); // see R02
				refused_next = (fmt_common == FMT_CMOS); // see R02
			end
			default: out2_en_next = 1'b0; // see R01
		endcase
		fmt_next = fmt_common; // see R03
		out5_en_next = 1'b1;
		out5_tri_next = 1'b0;
		fmt5_next = fmt_common; // see R03
		case (out5_code)
			TRI_LOW: fmt5_next = fmt_common; // see R03
			TRI_HIGH:
			begin
				out5_en_next = 1'b0; // see R05
				out5_tri_next = 1'b1; // see R05
				fmt5_next = FMT_DISABLE;
			end
			default: fmt5_next = FMT_CMOS; // see R04
		endcase
		// pairs are differential except in cmos, where both legs copy one clock
		diff_next = (fmt_common != FMT_CMOS); // see R12
		diff5_next = (fmt5_next != FMT_CMOS); // see R12
		offset_en_next = (offset_code != TRI_LOW); // see R07
		offset_sonet_next = (offset_code == TRI_HIGH); // see R07
	end

	// path control registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			out2_en_reg <= 1'b0;
			bypass_reg <= 1'b0;
			refused_reg <= 1'b0;
			out5_en_reg <= 1'b0;
			out5_tri_reg <= 1'b1;
			fmt_reg <= FMT_RESERVED;
			fmt5_reg <= FMT_DISABLE;
			diff_reg <= 1'b1;
			diff5_reg <= 1'b1;
			offset_en_reg <= 1'b0;
			offset_sonet_reg <= 1'b0;
		end
		else
		begin
			out2_en_reg <= out2_en_next;
			bypass_reg <= bypass_next;
			refused_reg <= refused_next;
			out5_en_reg <= out5_en_next;
			out5_tri_reg <= out5_tri_next;
			fmt_reg <= fmt_next;
			fmt5_reg <= fmt5_next;
			diff_reg <= diff_next;
			diff5_reg <= diff5_next;
			offset_en_reg <= offset_en_next;
			offset_sonet_reg <= offset_sonet_next;
		end
	end

	// settings passed through to the pll, held in flops for clean outputs
	logic [1:0] method_reg, method_next;
	logic [1:0] table_reg, table_next;
	logic [3:0] bw_reg, bw_next;
	logic [3:0] div_reg, div_next;
	logic [7:0] mul_reg, mul_next;

	// tables themselves live in the pll; here only the filtered codes
	always_comb
	begin
		method_next = method_code; // see R13
		table_next = tri_code[2*PIN_TABLE +: 2]; // see R10
		bw_next = tri_code[2*PIN_BW0 +: 4]; // see R11
		div_next = tri_code[2*PIN_DIV0 +: 4]; // see R09
		mul_next = tri_code[2*PIN_MUL0 +: 8]; // see R10
	end

	// settings registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			method_reg <= TRI_MID;
			table_reg <= TRI_MID;
			bw_reg <= {TRI_MID, TRI_MID};
			div_reg <= {TRI_MID, TRI_MID};
			mul_reg <= {TRI_MID, TRI_MID, TRI_MID, TRI_MID};
		end
		else
		begin
			method_reg <= method_next;
			table_reg <= table_next;
			bw_reg <= bw_next;
			div_reg <= div_next;
			mul_reg <= mul_next;
		end
	end

	// input 2 drops out of automatic choice on an offset alarm when qualified
	assign sel_valid = {input_valid[3:2],
		input_valid[1] & ~(offset_en_reg & frequency_offset_check), input_valid[0]}; // see R07

	// selection state
	cps_sel_t sel_reg, sel_next;
	logic [1:0] csout_reg, csout_next;
	logic csoe_reg, csoe_next;
	logic act1_reg, act1_next;
	logic act2_reg, act2_next;

	// manual follows the pins; revertive takes the lowest healthy input;
	// non-revertive keeps the current input while it stays healthy
	always_comb
	begin
		sel_next = sel_reg;
		case (method_reg)
			TRI_LOW: sel_next = cps_idx_to_sel(cs_code); // see R14
			TRI_HIGH:
			begin
				if (sel_valid[0])
					sel_next = SEL_IN1; // see R13
				else if (sel_valid[1])
					sel_next = SEL_IN2;
				else if (sel_valid[2])
					sel_next = SEL_IN3;
				else if (sel_valid[3])
					sel_next = SEL_IN4;
			end
			default:
			begin
				case (sel_reg)
					SEL_IN1: if (!sel_valid[0]) sel_next = SEL_IN2; // see R13
					SEL_IN2: if (!sel_valid[1]) sel_next = SEL_IN3;
					SEL_IN3: if (!sel_valid[2]) sel_next = SEL_IN4;
					SEL_IN4: if (!sel_valid[3]) sel_next = SEL_IN1;
					default: sel_next = SEL_IN1;
				endcase
				// steps one input per cycle; with none healthy it cycles, harmless
				// because no input can feed the pll then anyway
			end
		endcase
		act1_next = (sel_next == SEL_IN1); // see R08
		act2_next = (sel_next == SEL_IN2); // see R08
		csoe_next = (method_reg != TRI_LOW); // pins become indicators in automatic
		csout_next = {sel_next == SEL_IN4, sel_next == SEL_IN3};
	end

	// selection registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sel_reg <= SEL_IN1;
			csout_reg <= 2'h0;
			csoe_reg <= 1'b0;
			act1_reg <= 1'b0;
			act2_reg <= 1'b0;
		end
		else
		begin
			sel_reg <= sel_next;
			csout_reg <= csout_next;
			csoe_reg <= csoe_next;
			act1_reg <= act1_next;
			act2_reg <= act2_next;
		end
	end

	// outputs straight from flops
	assign out2_path_enable = out2_en_reg;
	assign pll_bypass = bypass_reg;
	assign bypass_refused = refused_reg;
	assign out5_path_enable = out5_en_reg;
	assign out5_tristate = out5_tri_reg;
	assign common_format = fmt_reg;
	assign out5_format = fmt5_reg;
	assign common_pair_differential = diff_reg;
	assign out5_pair_differential = diff5_reg;
	assign offset_enable = offset_en_reg;
	assign offset_sonet_threshold = offset_sonet_reg;
	assign selection_method = method_reg;
	assign table_setting = table_reg;
	assign bandwidth_setting = bw_reg;
	assign divider_setting = div_reg;
	assign multiplier_setting = mul_reg;
	assign input1_active_ind = act1_reg;
	assign input2_active_ind = act2_reg;
	assign clock_select_out = csout_reg;
	assign clock_select_oe = csoe_reg;

endmodule // cps_strap_ctrl

/* cps_strap_model.sv */
// board straps and host logic driving the three-level control pins
`timescale 1ns/1ns
module cps_strap_model
	import cps_pkg::*;
#(
	parameter int N = TRI_PINS
)
(
	input wire logic [2*N-1:0] lvl,
	input wire logic allow_bad,
	output logic [2*N-1:0] raw
);
	logic [2*N-1:0] pin; // levels after host policy
	// host policy, then comparator pair per pin; middle or floating leaves both clear
	always_comb
	begin
		pin = lvl;
		// a well-behaved host falls back to enable when formats are cmos
		if (!allow_bad && lvl[1:0] == TRI_HIGH && lvl[13:10] == {TRI_LOW, TRI_HIGH})
			pin[1:0] = TRI_LOW;
		for (int i = 0; i < N; i++)
			raw[2*i +: 2] = (pin[2*i +: 2] == TRI_HIGH) ? 2'h2 :
				(pin[2*i +: 2] == TRI_LOW) ? 2'h1 : 2'h0;
	end
endmodule // cps_strap_model

/* cps_strap_ctrl_asserts.sv */
// concurrent checks on the pin-strap control ports
`timescale 1ns/1ns
module cps_strap_ctrl_asserts
	import cps_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [1:0] out2_disable_bypass_sel,
	input wire logic out2_path_enable,
	input wire logic pll_bypass,
	input wire logic bypass_refused,
	input wire logic out5_path_enable,
	input wire logic out5_tristate,
	input wire logic [2:0] common_format,
	input wire logic [2:0] out5_format,
	input wire logic common_pair_differential,
	input wire logic out5_pair_differential,
	input wire logic offset_enable,
	input wire logic offset_sonet_threshold,
	input wire logic [1:0] selection_method,
	input wire logic clock_select_oe,
	input wire logic input1_active_ind,
	input wire logic input2_active_ind
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [8:0] hold_reg; // cycles the out2 pin held its level
	logic [8:0] hold_next;
	logic [1:0] last_reg; // out2 pin one cycle ago
	// saturating hold count, so long quiet spells never wrap
	always_comb
	begin
		hold_next = hold_reg;
		if (out2_disable_bypass_sel != last_reg)
			hold_next = 9'h000;
		else if (hold_reg != 9'h1ff)
			hold_next = hold_reg + 9'h001;
	end
	// register the hold count
	always_ff @(posedge clk)
	begin
		hold_reg <= rst ? 9'h000 : hold_next;
		last_reg <= out2_disable_bypass_sel;
	end
	sequence s_bypass_path;
		pll_bypass && out2_path_enable && !bypass_refused;
	endsequence
	sequence s_out5_off;
		!out5_path_enable && out5_format == FMT_DISABLE;
	endsequence
	AST_BYPASS_OUT2: assert property (pll_bypass |-> s_bypass_path)
		else $error("bypass without out2 path");
	AST_BYPASS_FMT: assert property (pll_bypass |-> common_format != FMT_CMOS)
		else $error("bypass with cmos outputs");
	AST_OUT5_COMMON: assert property (out5_path_enable && out5_format != FMT_CMOS
		|-> out5_format == common_format)
		else $error("out5 format differs from common");
	AST_OUT5_OFF: assert property (out5_tristate |-> s_out5_off)
		else $error("out5 tristate while active");
	AST_OUT5_HOLD: assert property ($rose(out5_tristate) |-> out5_tristate [*8])
		else $error("out5 power-down not held");
	AST_PAIR_COMMON: assert property (common_pair_differential
		== (common_format != FMT_CMOS))
		else $error("common pair mode wrong");
	AST_PAIR_OUT5: assert property (out5_pair_differential
		== (out5_format != FMT_CMOS))
		else $error("out5 pair mode wrong");
	AST_IND_EXCL: assert property (!(input1_active_ind && input2_active_ind))
		else $error("two inputs flagged active");
	AST_OFFSET_THRESH: assert property (offset_sonet_threshold |-> offset_enable)
		else $error("threshold without offset check");
	AST_OUT2_FILTER: assert property ($changed(out2_path_enable) || $changed(pll_bypass)
		|-> hold_reg >= 9'h0fa)
		else $error("out2 decode moved on a short pulse");
	AST_OE_METHOD: assert property (!$past(rst)
		|-> clock_select_oe == ($past(selection_method) != TRI_LOW))
		else $error("select pin direction wrong");
endmodule // cps_strap_ctrl_asserts
bind cps_strap_ctrl cps_strap_ctrl_asserts u_cps_strap_ctrl_asserts (.clk(clk), .rst(rst),
	.out2_disable_bypass_sel(out2_disable_bypass_sel), .out2_path_enable(out2_path_enable),
	.pll_bypass(pll_bypass), .bypass_refused(bypass_refused), .out5_path_enable(out5_path_enable),
	.out5_tristate(out5_tristate), .common_format(common_format), .out5_format(out5_format),
	.common_pair_differential(common_pair_differential),
	.out5_pair_differential(out5_pair_differential), .offset_enable(offset_enable),
	.offset_sonet_threshold(offset_sonet_threshold), .selection_method(selection_method),
	.clock_select_oe(clock_select_oe), .input1_active_ind(input1_active_ind),
	.input2_active_ind(input2_active_ind));

/* testbench.sv */
// self-checking bench for the pin-strap control block
`timescale 1ns/1ns
module testbench
	import cps_pkg::*;
	;
	logic clk, rst, bad, offset_alarm;
	logic [29:0] lvl; // requested level per pin slot
	logic [29:0] raw; // comparator pairs from the straps
	logic [1:0] cs_in, cs_out, meth, tbl;
	logic [3:0] valid, bw, dv;
	logic [7:0] mul;
	logic [2:0] cfmt, o5fmt;
	logic o2en, byp, refused, o5en, o5tri, cdiff, o5diff, fen, fson, a1, a2, cs_oe;
	int n_mismatch, checks;
	cps_strap_model u_cps_strap_model (.lvl(lvl), .allow_bad(bad), .raw(raw));
	cps_strap_ctrl u_cps_strap_ctrl (.clk(clk), .rst(rst), .out2_disable_bypass_sel(raw[1:0]),
		.out5_disable_format_sel(raw[3:2]), .freq_offset_qualify_sel(raw[5:4]),
		.input_selection_method(raw[7:6]), .frequency_table_sel(raw[9:8]),
		.output_format_sel(raw[13:10]), .loop_bandwidth_sel(raw[17:14]),
		.out3_out4_divider_sel(raw[21:18]), .multiplier_sel(raw[29:22]),
		.clock_select_in(cs_in), .clock_select_out(cs_out), .clock_select_oe(cs_oe),
		.input_valid(valid), .frequency_offset_check(offset_alarm), .out2_path_enable(o2en),
		.pll_bypass(byp), .bypass_refused(refused), .out5_path_enable(o5en),
		.out5_tristate(o5tri), .common_format(cfmt), .out5_format(o5fmt),
		.common_pair_differential(cdiff), .out5_pair_differential(o5diff),
		.offset_enable(fen), .offset_sonet_threshold(fson), .selection_method(meth),
		.table_setting(tbl),
		.bandwidth_setting(bw), .divider_setting(dv), .multiplier_setting(mul),
		.input1_active_ind(a1), .input2_active_ind(a2));
	// free-running clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic final_report();
		if (n_mismatch == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// wait n edges, then step just past the edge
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task automatic put(int s, logic [1:0] v);
		lvl[2*s +: 2] = v;
	endtask
	// format code of a {pin1, pin0} pair
	function automatic logic [2:0] fmt_of(logic [1:0] p1, logic [1:0] p0);
		case ({p1, p0})
			{TRI_HIGH, TRI_MID}: return FMT_LVDS;
			{TRI_HIGH, TRI_LOW}: return FMT_CML;
			{TRI_MID, TRI_HIGH}: return FMT_LVPECL;
			{TRI_MID, TRI_LOW}: return FMT_LVDS_LOW;
			{TRI_LOW, TRI_HIGH}: return FMT_CMOS;
			{TRI_LOW, TRI_MID}: return FMT_DISABLE;
			default: return FMT_RESERVED;
		endcase
	endfunction
	task automatic t_defaults();
		cyc(258);
		chk("method", meth, 8'h01);
		chk("mult", mul, 8'h55);
		chk("out5_format", o5fmt, FMT_CMOS);
		chk("offset_enable", fen, 8'h01);
		chk("out2_enable", o2en, 8'h00);
	endtask
	task automatic t_out2();
		put(PIN_FMT1, TRI_MID);
		put(PIN_FMT0, TRI_HIGH);
		for (int v = 0; v < 3; v++)
		begin
			put(PIN_OUT2, 2'(v));
			cyc(258);
			chk("out2_enable", o2en, v != 1);
			chk("bypass", byp, v == 2);
		end
	endtask
	// host breaks the bypass rule, then behaves; then a short pulse
	task automatic t_refuse();
		bad = 1'b1;
		put(PIN_FMT1, TRI_LOW);
		put(PIN_FMT0, TRI_HIGH);
		cyc(258);
		chk("bypass", byp, 8'h00);
		chk("refused", refused, 8'h01);
		bad = 1'b0;
		cyc(258);
		chk("refused", refused, 8'h00);
		chk("out2_enable", o2en, 8'h01);
		put(PIN_OUT2, TRI_MID);
		cyc(258);
		put(PIN_OUT2, TRI_LOW);
		cyc(100);
		chk("out2_enable", o2en, 8'h00);
		put(PIN_OUT2, TRI_MID);
		cyc(258);
		chk("out2_enable", o2en, 8'h00);
	endtask
	task automatic t_formats();
		logic [2:0] e;
		put(PIN_OUT5, TRI_LOW);
		for (int a = 0; a < 3; a++)
			for (int b = 0; b < 3; b++)
			begin
				put(PIN_FMT1, 2'(a));
				put(PIN_FMT0, 2'(b));
				e = fmt_of(2'(a), 2'(b));
				cyc(258);
				chk("common_format", cfmt, e);
				chk("out5_format", o5fmt, e);
				chk("pair_diff", cdiff, e != FMT_CMOS);
			end
		put(PIN_FMT1, TRI_HIGH);
		put(PIN_FMT0, TRI_MID);
		put(PIN_OUT5, TRI_MID);
		cyc(258);
		chk("out5_format", o5fmt, FMT_CMOS);
		chk("common_format", cfmt, FMT_LVDS);
		chk("out5_diff", o5diff, 8'h00);
		put(PIN_OUT5, TRI_HIGH);
		cyc(258);
		chk("out5_enable", o5en, 8'h00);
		chk("out5_tristate", o5tri, 8'h01);
	endtask
	task automatic t_straps();
		for (int v = 0; v < 3; v++)
		begin
			put(PIN_OFFSET, 2'(v));
			cyc(258);
			chk("offset_enable", fen, v != 0);
			chk("offset_sonet", fson, v == 2);
		end
		put(PIN_OFFSET, TRI_MID);
		put(PIN_TABLE, TRI_HIGH);
		put(PIN_BW0, TRI_LOW);
		put(PIN_DIV0, TRI_HIGH);
		put(PIN_DIV1, TRI_LOW);
		for (int k = 0; k < 4; k++)
			put(PIN_MUL0 + k, 2'(k % 3));
		cyc(258);
		chk("table", tbl, lvl[9:8]);
		chk("bandwidth", bw, lvl[17:14]);
		chk("divider", dv, lvl[21:18]);
		chk("mult", mul, lvl[29:22]);
	endtask
	task automatic t_select();
		put(PIN_METHOD, TRI_LOW);
		for (int i = 0; i < 4; i++)
		begin
			cs_in = 2'(i);
			cyc(258);
			chk("ind1", a1, i == 0);
			chk("ind2", a2, i == 1);
			chk("cs_out", cs_out, {i == 3, i == 2});
			chk("cs_oe", cs_oe, 8'h00);
		end
		cs_in = 2'h0;
		cyc(100);
		chk("ind1", a1, 8'h00);
		cs_in = 2'h3;
		put(PIN_METHOD, TRI_HIGH);
		cyc(258);
		chk("ind1", a1, 8'h01);
		chk("cs_oe", cs_oe, 8'h01);
		valid = 4'he;
		cyc(4);
		chk("ind2", a2, 8'h01);
		offset_alarm = 1'b1;
		cyc(4);
		chk("cs_out", cs_out, 8'h01);
		put(PIN_METHOD, TRI_MID);
		cyc(258);
		offset_alarm = 1'b0;
		valid = 4'hf;
		cyc(6);
		chk("cs_out", cs_out, 8'h01);
		valid = 4'hb;
		cyc(6);
		chk("cs_out", cs_out, 8'h02);
	endtask
	// hang guard, well past the expected run
	initial
	begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		final_report();
	end
	// main sequence
	initial
	begin
		rst = 1'b1;
		lvl = {15{TRI_MID}};
		bad = 1'b0;
		cs_in = 2'h0;
		valid = 4'hf;
		offset_alarm = 1'b0;
		n_mismatch = 0;
		checks = 0;
		cyc(10);
		rst = 1'b0;
		t_defaults();
		t_out2();
		t_refuse();
		t_formats();
		t_straps();
		t_select();
		final_report();
	end
endmodule // testbench
